// ---- include/pnbc_pkg.sv ----
// Constants and types shared by the burn controller ends and the link.
// Assumes one 25 MHz clock (aclk) and a synchronous active-low reset.
//
// Behaviour
// RULE_01 - At most three burns store new defaults
// RULE_02 - Host burns only after filling parameter memory
// RULE_03 - Host burns only in active or doze
// RULE_04 - Burn done sets flag bit 6, interrupt
// RULE_05 - Reset reloads last burned parameters
// RULE_06 - Burn count readable in status bits 2:0
// RULE_07 - Delivered: empty store, count zero, factory
// RULE_08 - Each burn counts; fourth forces factory (count holds at 7)
// RULE_09 - Host unlocks with 0x62 then 0x9D
// RULE_10 - Host triggers with 0xA5 then 0x5A
// RULE_11 - Sequence ends in STOP; burn after it
// RULE_12 - High key register at 0xAC, value 0x62
// RULE_13 - Low key register at 0xAD, value 0x9D
// RULE_14 - Mode: 00 active, 01 doze, 10 sleep
// RULE_15 - Reading interrupt flags clears them
// RULE_16 - Wrong value or order: no burn
package pnbc_pkg;
  // ----------------------------------------
  // Device register map (link addresses)
  // ----------------------------------------
  localparam int         PM_DEPTH     = 128;
  localparam int         PM_AW        = 7;
  localparam logic [7:0] A_IRQ_SRC    = 8'h00;
  localparam logic [7:0] A_PM_STAT    = 8'h08;
  localparam logic [7:0] A_MODE       = 8'h09;
  localparam logic [7:0] A_PM_CFG     = 8'h0d;
  localparam logic [7:0] A_PB_BASE    = 8'h0e;
  localparam logic [7:0] A_KEY_HIGH   = 8'hac;
  localparam logic [7:0] A_KEY_LOW    = 8'had;
  localparam logic [7:0] KEY_HIGH_VAL = 8'h62;
  localparam logic [7:0] KEY_LOW_VAL  = 8'h9d;
  localparam logic [7:0] TRIG_1_VAL   = 8'ha5;
  localparam logic [7:0] TRIG_2_VAL   = 8'h5a;
  localparam int         IRQ_BURN_BIT = 6;
  localparam logic [1:0] MODE_ACTIVE  = 2'b00;
  localparam logic [1:0] MODE_DOZE    = 2'b01;
  localparam logic [1:0] MODE_SLEEP   = 2'b10;
  localparam logic [1:0] PM_CFG_ON    = 2'b01;
  localparam logic [2:0] BURN_LIMIT   = 3'h3;
  localparam logic [2:0] COUNT_MAX    = 3'h7;
  localparam logic [2:0] COUNT_RST    = 3'h0;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  // ----------------------------------------
  // Host controller register map (AXI4-Lite)
  // ----------------------------------------
  localparam logic [7:0] H_CMD  = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam logic [7:0] H_IRQ  = 8'h08;
  localparam logic [7:0] H_MASK = 8'h0c;
  localparam logic [7:0] H_BURN = 8'h10;
  localparam int         H_IRQ_W = 3;
  localparam logic [2:0] H_IRQ_RST = 3'h0;
  localparam logic [2:0] SEQ_LAST  = 3'h4;

  typedef enum logic [1:0] {OP_WR, OP_RD, OP_STOP} pnbc_op_e;

  // Factory default for one parameter byte; pattern is arbitrary
  function automatic logic [7:0] pnbc_fdef(input logic [PM_AW-1:0] a);
    return {1'b0, a} ^ 8'h3c;
  endfunction
endpackage

// ---- include/pnbc_link_if.sv ----
// Register-level link between host end and device end.
// Assumes both ends share aclk; one transfer per pulse.
`timescale 1ns/1ps
`default_nettype none
interface pnbc_link_if (input wire logic aclk);
  logic       wr;
  logic       rd;
  logic       stop;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rack;
  logic       irq;

  modport device (input wr, rd, stop, addr, wdata,
                  output rdata, rack, irq);
  modport host   (output wr, rd, stop, addr, wdata,
                  input rdata, rack, irq);
endinterface
`default_nettype wire

// ---- logic/pnbc_nvm.sv ----
// Non-volatile parameter store with burn counter and factory flag.
// Assumes aresetn does not reach it; erase models the delivered state.
`timescale 1ns/1ps
`default_nettype none
module pnbc_nvm #(
  parameter int DEPTH = pnbc_pkg::PM_DEPTH,
  parameter int AW    = pnbc_pkg::PM_AW
) (
  input  wire logic          aclk,
  input  wire logic          erase,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata,
  input  wire logic          bump,
  output logic      [2:0]    count,
  output logic               factory
);
  logic [7:0] mem [DEPTH];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

  // ----------------------------------------
  // Counter; survives aresetn on purpose
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (erase) begin
      count   <= pnbc_pkg::COUNT_RST; // RULE_07
      factory <= 1'b0;
    end else if (bump) begin
      if (count != pnbc_pkg::COUNT_MAX) begin
        count <= count + 3'h1; // RULE_08
      end
      if (count >= pnbc_pkg::BURN_LIMIT) begin
        factory <= 1'b1; // RULE_08
      end
    end
  end
endmodule // pnbc_nvm
`default_nettype wire

// ---- logic/pnbc_device.sv ----
// Device end: working parameter memory, burn sequence detector,
// burn engine and interrupt flags. Assumes the link modport drives
// one-cycle strobes on aclk; nvm_erase restores the delivered state.
`timescale 1ns/1ps
`default_nettype none
module pnbc_device (
  input  wire logic    aclk,
  input  wire logic    aresetn,
  input  wire logic    nvm_erase,
  pnbc_link_if.device  link,
  output logic         busy,
  output logic [1:0]   mode,
  output logic [2:0]   burn_count
);
  localparam int AW = pnbc_pkg::PM_AW;

  typedef enum logic [2:0] {
    S_LOAD, S_IDLE, S_KEY1, S_KEY2, S_TRIG1, S_ARMED, S_BURN
  } pnbc_dev_st_e;

  pnbc_dev_st_e   st_q;
  logic [AW-1:0]  idx_q;
  logic [7:0]     pm_q [pnbc_pkg::PM_DEPTH];
  logic [7:0]     irq_src_q;
  logic [1:0]     mode_q;
  logic [7:0]     cfg_q;
  logic [7:0]     base_q;
  logic [7:0]     rdata_q;
  logic           rack_q;
  logic [7:0]     nvm_rd;
  logic [2:0]     cnt;
  logic           factory;
  logic           burn_done;
  logic           last_idx;
  logic           win_hit;
  logic [AW-1:0]  win_addr;
  logic           use_fdef;

  // Parameter window open in gateway mode, link addresses 0..7
  function automatic logic pnbc_in_win(input logic [7:0] a,
                                       input logic [7:0] cfg);
    return (cfg[5:4] == pnbc_pkg::PM_CFG_ON) && (a[7:3] == 5'h00);
  endfunction

  assign last_idx = (idx_q == AW'(pnbc_pkg::PM_DEPTH - 1));
  assign win_hit  = pnbc_in_win(link.addr, cfg_q);
  assign win_addr = AW'(base_q + {5'h00, link.addr[2:0]});
  assign use_fdef = (cnt == pnbc_pkg::COUNT_RST) || factory; // RULE_07
  assign burn_done = (st_q == S_BURN) && (last_idx || factory);

  pnbc_nvm pnbc_nvm_inst (
    .aclk    (aclk),
    .erase   (nvm_erase),
    .we      ((st_q == S_BURN) && !factory),
    .waddr   (idx_q),
    .wdata   (pm_q[idx_q]),
    .raddr   (idx_q),
    .rdata   (nvm_rd),
    .bump    (burn_done),
    .count   (cnt),
    .factory (factory)
  );

  // ----------------------------------------
  // Burn sequence and engine
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= S_LOAD;
      idx_q <= '0;
    end else begin
      unique case (st_q)
        S_LOAD: begin
          idx_q <= idx_q + AW'(1);
          if (last_idx) begin
            st_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          // Sleep blocks the sequence rather than half-burning
          if (link.wr && link.addr == pnbc_pkg::A_KEY_HIGH && // RULE_12
              link.wdata == pnbc_pkg::KEY_HIGH_VAL &&
              mode_q != pnbc_pkg::MODE_SLEEP) begin // RULE_03
            st_q <= S_KEY1;
          end
        end
        S_KEY1: begin
          if (link.wr) begin
            st_q <= (link.addr == pnbc_pkg::A_KEY_LOW && // RULE_13
                     link.wdata == pnbc_pkg::KEY_LOW_VAL) ?
                    S_KEY2 : S_IDLE; // RULE_16
          end
        end
        S_KEY2: begin
          if (link.wr) begin
            st_q <= (link.addr == pnbc_pkg::A_PB_BASE &&
                     link.wdata == pnbc_pkg::TRIG_1_VAL) ?
                    S_TRIG1 : S_IDLE; // RULE_16
          end
        end
        S_TRIG1: begin
          if (link.wr) begin
            st_q <= (link.addr == pnbc_pkg::A_PB_BASE &&
                     link.wdata == pnbc_pkg::TRIG_2_VAL) ?
                    S_ARMED : S_IDLE; // RULE_16
          end
        end
        S_ARMED: begin
          if (link.wr) begin
            st_q <= S_IDLE; // RULE_16
          end else if (link.stop) begin
            st_q  <= S_BURN; // RULE_11
            idx_q <= '0;
          end
        end
        S_BURN: begin
          idx_q <= idx_q + AW'(1); // RULE_01
          if (burn_done) begin
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Working parameter memory
  // ----------------------------------------
  // Link writes during reload are dropped so the reload stays whole
  always_ff @(posedge aclk) begin
    if (st_q == S_LOAD) begin
      pm_q[idx_q] <= use_fdef ? pnbc_pkg::pnbc_fdef(idx_q) : nvm_rd; // RULE_05
    end else if (link.wr && win_hit && !cfg_q[3]) begin
      pm_q[win_addr] <= link.wdata;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= pnbc_pkg::MODE_ACTIVE;
      cfg_q  <= pnbc_pkg::BYTE_RST;
      base_q <= pnbc_pkg::BYTE_RST;
    end else if (link.wr && st_q != S_LOAD && !win_hit) begin
      if (link.addr == pnbc_pkg::A_MODE &&
          link.wdata[1:0] != 2'b11) begin
        mode_q <= link.wdata[1:0]; // RULE_14
      end
      if (link.addr == pnbc_pkg::A_PM_CFG) begin
        cfg_q <= {2'b00, link.wdata[5:3], 3'b000};
      end
      // Trigger values are not valid bases and are not stored
      if (link.addr == pnbc_pkg::A_PB_BASE &&
          link.wdata != pnbc_pkg::TRIG_1_VAL &&
          link.wdata != pnbc_pkg::TRIG_2_VAL) begin
        base_q <= {link.wdata[7:3], 3'b000};
      end
    end
  end

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_src_q <= pnbc_pkg::BYTE_RST;
    end else begin
      if (link.rd && !win_hit && link.addr == pnbc_pkg::A_IRQ_SRC) begin
        irq_src_q <= pnbc_pkg::BYTE_RST; // RULE_15
      end
      // Set after clear: a finishing burn is never lost
      if (burn_done) begin
        irq_src_q[pnbc_pkg::IRQ_BURN_BIT] <= 1'b1; // RULE_04
      end
    end
  end

  // ----------------------------------------
  // Read path, answered the cycle after rd
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= pnbc_pkg::BYTE_RST;
      rack_q  <= 1'b0;
    end else begin
      rack_q <= link.rd;
      if (link.rd) begin
        if (win_hit) begin
          rdata_q <= pm_q[win_addr];
        end else begin
          unique case (link.addr)
            pnbc_pkg::A_IRQ_SRC: rdata_q <= irq_src_q;
            pnbc_pkg::A_PM_STAT: rdata_q <= {4'h0, factory, cnt}; // RULE_06
            pnbc_pkg::A_MODE:    rdata_q <= {6'h00, mode_q};
            pnbc_pkg::A_PM_CFG:  rdata_q <= cfg_q;
            pnbc_pkg::A_PB_BASE: rdata_q <= base_q;
            default:             rdata_q <= pnbc_pkg::BYTE_RST;
          endcase
        end
      end
    end
  end

  assign link.rdata = rdata_q;
  assign link.rack  = rack_q;
  assign link.irq   = |irq_src_q; // RULE_04
  assign busy       = (st_q == S_LOAD) || (st_q == S_BURN);
  assign mode       = mode_q;
  assign burn_count = cnt;
endmodule // pnbc_device
`default_nettype wire

// ---- logic/pnbc_host.sv ----
// Host end: AXI4-Lite command registers driving the link, with an
// automatic burn sequence. Assumes the device answers reads on link.rack.
`timescale 1ns/1ps
`default_nettype none
module pnbc_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  pnbc_link_if.host        link,
  output logic             irq
);
  logic [7:0]  awaddr_q;
  logic        aw_q;
  logic [31:0] wdata_q;
  logic        w_q;
  logic        w_stb_q;
  logic        do_wr;
  logic [2:0]  seq_q;
  logic        seq_on_q;
  logic        rd_wait_q;
  logic [7:0]  rbyte_q;
  logic [2:0]  ist_q;
  logic [2:0]  mask_q;
  logic        dirq_q;
  logic        busy;

  assign do_wr = aw_q && w_q && !s_axi_bvalid;
  assign busy  = seq_on_q || rd_wait_q;

  // ----------------------------------------
  // AXI4-Lite slave; unmapped reads give 0
  // ----------------------------------------
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp   = 2'b00;
  assign s_axi_rresp   = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      w_stb_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        // Strobe belongs to the beat; the master may move it once taken
        w_stb_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        pnbc_pkg::H_STAT: s_axi_rdata <= {22'h0, dirq_q, busy, rbyte_q};
        pnbc_pkg::H_IRQ:  s_axi_rdata <= {29'h0, ist_q};
        pnbc_pkg::H_MASK: s_axi_rdata <= {29'h0, mask_q};
        default:          s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Link driver; commands while busy are dropped
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
      link.stop  <= 1'b0;
      link.addr  <= '0;
      link.wdata <= '0;
      seq_q      <= '0;
      seq_on_q   <= 1'b0;
      rd_wait_q  <= 1'b0;
      rbyte_q    <= '0;
    end else begin
      link.wr   <= 1'b0;
      link.rd   <= 1'b0;
      link.stop <= 1'b0;
      if (link.rack) begin
        rd_wait_q <= 1'b0;
        rbyte_q   <= link.rdata;
      end
      if (seq_on_q) begin
        seq_q <= seq_q + 3'h1;
        unique case (seq_q)
          3'h0: begin
            link.wr    <= 1'b1;
            link.addr  <= pnbc_pkg::A_KEY_HIGH; // RULE_09
            link.wdata <= pnbc_pkg::KEY_HIGH_VAL;
          end
          3'h1: begin
            link.wr    <= 1'b1;
            link.addr  <= pnbc_pkg::A_KEY_LOW; // RULE_09
            link.wdata <= pnbc_pkg::KEY_LOW_VAL;
          end
          3'h2: begin
            link.wr    <= 1'b1;
            link.addr  <= pnbc_pkg::A_PB_BASE; // RULE_10
            link.wdata <= pnbc_pkg::TRIG_1_VAL;
          end
          3'h3: begin
            link.wr    <= 1'b1;
            link.addr  <= pnbc_pkg::A_PB_BASE; // RULE_10
            link.wdata <= pnbc_pkg::TRIG_2_VAL;
          end
          default: begin
            link.stop <= 1'b1; // RULE_11
            seq_on_q  <= 1'b0;
          end
        endcase
      end else if (do_wr && !busy) begin
        if (awaddr_q == pnbc_pkg::H_BURN) begin
          seq_on_q <= 1'b1;
          seq_q    <= '0;
        end else if (awaddr_q == pnbc_pkg::H_CMD) begin
          link.addr  <= wdata_q[15:8];
          link.wdata <= wdata_q[7:0];
          unique case (wdata_q[17:16])
            2'(pnbc_pkg::OP_WR): link.wr <= 1'b1;
            2'(pnbc_pkg::OP_RD): begin
              link.rd   <= 1'b1;
              rd_wait_q <= 1'b1;
            end
            2'(pnbc_pkg::OP_STOP): link.stop <= 1'b1;
            default: link.stop <= 1'b0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupts: bit0 read done, bit1 device irq, bit2 burn sent
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q  <= pnbc_pkg::H_IRQ_RST;
      mask_q <= pnbc_pkg::H_IRQ_RST;
      dirq_q <= 1'b0;
    end else begin
      dirq_q <= link.irq;
      if (do_wr && awaddr_q == pnbc_pkg::H_MASK && w_stb_q) begin
        mask_q <= wdata_q[2:0];
      end
      // Clear first, then set, so a same-cycle event wins
      if (do_wr && awaddr_q == pnbc_pkg::H_IRQ && w_stb_q) begin
        ist_q <= ist_q & ~wdata_q[2:0];
      end
      if (link.rack) begin
        ist_q[0] <= 1'b1;
      end
      if (link.irq && !dirq_q) begin
        ist_q[1] <= 1'b1;
      end
      if (seq_on_q && seq_q == pnbc_pkg::SEQ_LAST) begin
        ist_q[2] <= 1'b1;
      end
    end
  end

  assign irq = |(ist_q & mask_q);
endmodule // pnbc_host
`default_nettype wire

// ---- tb/pnbc_link_sva.sv ----
// Assertions on the burn controller link and device outputs.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none
module pnbc_link_sva (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       nvm_erase,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic       stop,
  input wire logic [7:0] addr,
  input wire logic       rack,
  input wire logic       irq,
  input wire logic       busy,
  input wire logic [1:0] mode,
  input wire logic [2:0] burn_count
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Ages the last STOP so a burn start can be tied to it
  logic [7:0] since_stop_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_stop_q <= 8'hff;
    end else if (stop) begin
      since_stop_q <= 8'h00;
    end else if (since_stop_q != 8'hff) begin
      since_stop_q <= since_stop_q + 8'h01;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rack_follow_a: assert property (rd |=> rack)
    else $error("read not answered next cycle");
  rack_cause_a: assert property (rack |-> $past(rd))
    else $error("answer without a read");
  irq_clear_a: assert property (
    rd && addr == pnbc_pkg::A_IRQ_SRC && !busy |=> !irq)
    else $error("flag read left interrupt high");
  mode_legal_a: assert property (mode != 2'b11)
    else $error("reserved mode taken");
  reset_quiet_a: assert property (disable iff (nvm_erase)
    !aresetn |=> !rack && !irq)
    else $error("outputs active in reset");
  count_hold_a: assert property (disable iff (nvm_erase)
    !aresetn |=> $stable(burn_count))
    else $error("reset disturbed burn count");
  count_step_a: assert property (disable iff (nvm_erase)
    $changed(burn_count) |-> burn_count == $past(burn_count) + 3'h1)
    else $error("burn count moved by other than one");
  burn_stop_a: assert property (
    $rose(busy) && $past(aresetn, 3) |-> since_stop_q <= 8'h08)
    else $error("burn started without a STOP");
  reload_busy_a: assert property (
    $rose(aresetn) |-> ##[0:2] busy)
    else $error("no reload after reset");

  cover property ($rose(irq));
  cover property (wr && addr == pnbc_pkg::A_KEY_HIGH);
  cover property (burn_count == 3'h4);
endmodule // pnbc_link_sva
`default_nettype wire

// ---- tb/parameter_nvm_burn_control_tb.sv ----
// Bench joining host and device ends over the link.
// Assumes AXI4-Lite host registers and device map of the package.
`timescale 1ns/1ps
`default_nettype none
module parameter_nvm_burn_control_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        nvm_erase = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        irq;
  logic        busy;
  logic [1:0]  mode;
  logic [2:0]  burn_count;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #20 aclk = ~aclk;

  pnbc_link_if link (.aclk(aclk));
  pnbc_host pnbc_host_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .link(link), .irq(irq));
  pnbc_device pnbc_device_inst (
    .aclk(aclk), .aresetn(aresetn), .nvm_erase(nvm_erase),
    .link(link), .busy(busy), .mode(mode), .burn_count(burn_count));
  pnbc_link_sva pnbc_link_sva_inst (
    .aclk(aclk), .aresetn(aresetn), .nvm_erase(nvm_erase),
    .wr(link.wr), .rd(link.rd), .stop(link.stop), .addr(link.addr),
    .rack(link.rack), .irq(link.irq), .busy(busy), .mode(mode),
    .burn_count(burn_count));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic close_out;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang ends the run through the same report
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the falling edge, where they have settled;
  // reading them just after the rising edge races the slave's update
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_hs;
    bit w_hs;
    bit b_hs;
    b_hs = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      if (b_hs) chk(s_axi_bresp, 32'h0);
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    bit ar_hs;
    bit r_hs;
    r_hs = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      if (r_hs) begin
        d = s_axi_rdata;
        chk(s_axi_rresp, 32'h0);
      end
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic lnk(input logic [1:0] op, input logic [7:0] a,
                     input logic [7:0] d);
    axi_wr(pnbc_pkg::H_CMD, {14'h0, op, a, d});
  endtask

  // Device read: poll host busy until the answer byte lands
  task automatic drd(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] s;
    lnk(pnbc_pkg::OP_RD, a, 8'h00);
    s = 32'h100;
    for (int n = 0; n < 20 && s[8] !== 1'b0; n++) begin
      axi_rd(pnbc_pkg::H_STAT, s);
    end
    d = s[7:0];
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    nvm_erase <= 1'b0;
    repeat (3) @(posedge aclk);
    for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge aclk);
  endtask

  task automatic blk_wr;
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PM_CFG, 8'h10);
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PB_BASE, 8'h00);
    for (int n = 0; n < 8; n++) lnk(pnbc_pkg::OP_WR, 8'(n), 8'ha0 + 8'(n));
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PM_CFG, 8'h00);
  endtask

  task automatic blk_chk(input bit fac);
    logic [7:0] b;
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PM_CFG, 8'h18);
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PB_BASE, 8'h00);
    for (int n = 0; n < 8; n++) begin
      drd(8'(n), b);
      chk(b, fac ? 8'h3c ^ 8'(n) : 8'ha0 + 8'(n));
    end
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PM_CFG, 8'h00);
  endtask

  // One full burn, then flag read which must drop the line
  task automatic burn(input logic [2:0] exp);
    logic [7:0] f;
    axi_wr(pnbc_pkg::H_BURN, 32'h1);
    for (int n = 0; n < 1000 && link.irq !== 1'b1; n++) @(negedge aclk);
    chk(burn_count, exp);
    drd(pnbc_pkg::A_PM_STAT, f);
    chk(f[2:0], exp);
    drd(pnbc_pkg::A_IRQ_SRC, f);
    chk(f[pnbc_pkg::IRQ_BURN_BIT], 1'b1);
    chk(link.irq, 1'b0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] f;
    logic [31:0] s;
    do_reset;
    chk(burn_count, 3'h0);
    chk(mode, pnbc_pkg::MODE_ACTIVE);
    blk_chk(1'b1);
    blk_wr;
    drd(pnbc_pkg::A_IRQ_SRC, f);
    // Keys swapped: the whole sequence must be ignored
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_KEY_LOW, pnbc_pkg::KEY_LOW_VAL);
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_KEY_HIGH, pnbc_pkg::KEY_HIGH_VAL);
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PB_BASE, pnbc_pkg::TRIG_1_VAL);
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_PB_BASE, pnbc_pkg::TRIG_2_VAL);
    lnk(pnbc_pkg::OP_STOP, 8'h00, 8'h00);
    repeat (300) @(posedge aclk);
    chk(burn_count, 3'h0);
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_MODE, {6'h0, pnbc_pkg::MODE_SLEEP});
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_MODE, 8'h03);
    repeat (2) @(posedge aclk);
    chk(mode, pnbc_pkg::MODE_SLEEP);
    axi_wr(pnbc_pkg::H_BURN, 32'h1);
    repeat (300) @(posedge aclk);
    chk(burn_count, 3'h0);
    lnk(pnbc_pkg::OP_WR, pnbc_pkg::A_MODE, {6'h0, pnbc_pkg::MODE_DOZE});
    repeat (2) @(posedge aclk);
    chk(mode, pnbc_pkg::MODE_DOZE);
    axi_wr(pnbc_pkg::H_IRQ, 32'h7);
    axi_wr(pnbc_pkg::H_MASK, 32'h4);
    burn(3'h1);
    chk(irq, 1'b1);
    axi_rd(pnbc_pkg::H_IRQ, s);
    chk(s[2:0], 3'h7);
    axi_wr(pnbc_pkg::H_IRQ, 32'h4);
    axi_rd(pnbc_pkg::H_IRQ, s);
    chk({s[2], irq}, 2'b00);
    axi_wr(pnbc_pkg::H_MASK, 32'h0);
    do_reset;
    chk(burn_count, 3'h1);
    blk_chk(1'b0);
    burn(3'h2);
    burn(3'h3);
    burn(3'h4);
    drd(pnbc_pkg::A_PM_STAT, f);
    chk(f[3], 1'b1);
    do_reset;
    blk_chk(1'b1);
    close_out;
  end
endmodule // parameter_nvm_burn_control_tb
`default_nettype wire
